// file: logic/gp6_cfg.svh
// Offsets, field positions, reset values and pin numbers for the port-six block
`ifndef GP6_CFG_SVH
`define GP6_CFG_SVH

`define GP6_ADDR_W        4
`define GP6_OFF_DATA      4'h0
`define GP6_OFF_DIR       4'h1
`define GP6_OFF_PULL      4'h2
`define GP6_OFF_STBY      4'h3
`define GP6_OFF_STATUS    4'h4

`define GP6_RST_DATA      8'h00
`define GP6_RST_DIR       8'h00
`define GP6_RST_PULL      8'h00
`define GP6_RST_STBY      8'h00

`define GP6_STBY_PIN_BIT  0
`define GP6_STBY_SCK_BIT  1
`define GP6_STBY_SIN_BIT  2

`define GP6_PIN_SCK       5
`define GP6_PIN_SIN       7
`define GP6_PIN_TCLK      4

// Peripheral outputs exist on pins 0-3, 5 and 6 only
`define GP6_PERIPH_OE_MASK 8'h6F

`endif

// file: logic/gp6_pkg.sv
// Types shared by the port-six block
package gp6_pkg;

   // Register bus request from the CPU side
   typedef struct packed {
      logic [3:0] addr;
      logic [7:0] wdata;
      logic       wr;
      logic       rd;
      logic       rmw;
   } gp6_req_t;

   // Peripheral outputs that may take over pins 0, 1, 2, 3, 5 and 6
   typedef struct packed {
      logic [7:0] oe;
      logic [7:0] dout;
   } gp6_periph_t;

   typedef enum logic {
      GP6_RUN,
      GP6_PARK
   } gp6_mode_t;

endpackage : gp6_pkg

// file: logic/gp6_port.sv
// Eight-pin general-purpose port with shared peripheral pins and standby parking
`include "gp6_cfg.svh"

//----------------------------------------------------------------------
// How it works
// - Direction bit one makes pin an output
// - Output pin drives its data latch bit
// - Data write updates latch, shows on outputs
// - Output pin reads back latch, not pin
// - Direction bit zero makes pin an input
// - Input pin latch updates but stays undriven
// - Input pin: ordinary read pin, RMW latch
// - Peripheral output enable takes over the pin
// - Peripheral-driven pin reads pin level; RMW latch
// - Ordinary read shows pin despite peripheral input
// - Reset clears all direction bits
// - Standby with pin bit forces high impedance
// - Parked pins block input; parked input pins read low
// - Serial clock/data-in stay open if enabled
// - Pin bit zero keeps pins unchanged
// - Pull-up select bit connects pull-up
// - Low driven output disconnects pull-up
// - Register bit n maps to pin n
// - Fixed pin sharing with pulse, timer, serial
//----------------------------------------------------------------------

module gp6_port
   import gp6_pkg::*;
#(
   parameter int WIDTH = 8
) (
   // Clock, reset, enable
   input  wire logic              i_clk,
   input  wire logic              i_nrst,
   input  wire logic              i_ce,
   // Register port
   input  wire gp6_req_t          i_req,
   output logic [7:0]             o_rdata,
   // Standby request from the power controller (stop or watch)
   input  wire logic              i_standby,
   // Interrupt enables for the serial clock and data-in pins
   input  wire logic              i_irq_sck_en,
   input  wire logic              i_irq_sin_en,
   // Peripheral side
   input  wire logic              i_pulse_gen1_out_a,
   input  wire logic              i_pulse_gen1_out_b,
   input  wire logic              i_comp_timer1_out_a,
   input  wire logic              i_comp_timer1_out_b,
   input  wire logic              i_serial_clk_out,
   input  wire logic              i_serial_data_out,
   input  wire logic [WIDTH-1:0]  i_periph_oe,
   output logic                   o_comp_timer1_clk_in,
   output logic                   o_serial_clk_in,
   output logic                   o_serial_data_in,
   // Pins
   input  wire logic [WIDTH-1:0]  i_pin,
   output logic [WIDTH-1:0]       o_pin,
   output logic [WIDTH-1:0]       o_pin_oe,
   output logic [WIDTH-1:0]       o_pullup_en
);

   //----------------------------------------------------------------------
   // Registers and state
   //----------------------------------------------------------------------
   logic [WIDTH-1:0] data_r;
   logic [WIDTH-1:0] dir_r;
   logic [WIDTH-1:0] pull_r;
   logic [7:0]       stby_r;
   gp6_mode_t        mode_r;
   logic [WIDTH-1:0] sync1_r;
   logic [WIDTH-1:0] sync2_r;
   logic [WIDTH-1:0] sync3_r;
   logic [WIDTH-1:0] pin_lvl_r;
   gp6_periph_t      per;
   logic [WIDTH-1:0] open_mask;
   logic [WIDTH-1:0] in_gated;
   logic [WIDTH-1:0] drv_oe;
   logic [WIDTH-1:0] drv_val;
   logic [7:0]       rdata_nxt;
   logic             parked;

   function automatic logic hit(input gp6_req_t r, input logic [3:0] off);
      hit = (r.addr == off);
   endfunction : hit

   //----------------------------------------------------------------------
   // Peripheral pin sharing
   //----------------------------------------------------------------------
   always_comb begin
      per.dout    = '0;
      per.dout[0] = i_pulse_gen1_out_a;
      per.dout[1] = i_pulse_gen1_out_b;
      per.dout[2] = i_comp_timer1_out_a;
      per.dout[3] = i_comp_timer1_out_b;
      per.dout[5] = i_serial_clk_out;
      per.dout[6] = i_serial_data_out;
      // Pins 4 and 7 are input-only for their peripherals
      per.oe      = i_periph_oe & `GP6_PERIPH_OE_MASK;
   end

   //----------------------------------------------------------------------
   // Pin drive
   //----------------------------------------------------------------------
   assign parked = (mode_r == GP6_PARK);

   genvar g;
   generate
      for (g = 0; g < WIDTH; g++) begin : g_pin
         // Peripheral wins over the latch; software must avoid both at once
         assign drv_oe[g]  = per.oe[g] | dir_r[g];
         assign drv_val[g] = per.oe[g] ? per.dout[g] : data_r[g];
      end
   endgenerate

   // Standby mode tracking; pin bit zero leaves everything as it was
   always_ff @(posedge i_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         mode_r <= GP6_RUN;
      end else if (i_ce) begin
         if (i_standby && stby_r[`GP6_STBY_PIN_BIT]) begin
            mode_r <= GP6_PARK;
         end else begin
            mode_r <= GP6_RUN;
         end
      end
   end

   always_ff @(posedge i_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         o_pin       <= '0;
         o_pin_oe    <= '0;
         o_pullup_en <= '0;
      end else if (i_ce) begin
         o_pin       <= drv_val;
         o_pin_oe    <= parked ? '0 : drv_oe;
         // Pull-up dropped while driving low to avoid needless current
         o_pullup_en <= parked ? '0 : (pull_r & ~(drv_oe & ~drv_val));
      end
   end

   //----------------------------------------------------------------------
   // Input path
   //----------------------------------------------------------------------
   always_ff @(posedge i_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         sync1_r <= '0;
         sync2_r <= '0;
         sync3_r <= '0;
      end else if (i_ce) begin
         sync1_r <= i_pin;
         sync2_r <= sync1_r;
         sync3_r <= sync2_r;
      end
   end

   generate
      for (g = 0; g < WIDTH; g++) begin : g_in
         // A level change counts once two stages agree
         always_ff @(posedge i_clk or negedge i_nrst) begin
            if (!i_nrst) begin
               pin_lvl_r[g] <= 1'b0;
            end else if (i_ce && (sync2_r[g] == sync3_r[g])) begin
               pin_lvl_r[g] <= sync3_r[g];
            end
         end
      end
   endgenerate

   always_comb begin
      open_mask                 = parked ? '0 : '1;
      open_mask[`GP6_PIN_SCK]   = ~parked | stby_r[`GP6_STBY_SCK_BIT] | i_irq_sck_en;
      open_mask[`GP6_PIN_SIN]   = ~parked | stby_r[`GP6_STBY_SIN_BIT] | i_irq_sin_en;
      in_gated                  = pin_lvl_r & open_mask;
   end

   always_ff @(posedge i_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         o_comp_timer1_clk_in <= 1'b0;
         o_serial_clk_in      <= 1'b0;
         o_serial_data_in     <= 1'b0;
      end else if (i_ce) begin
         o_comp_timer1_clk_in <= in_gated[`GP6_PIN_TCLK];
         o_serial_clk_in      <= in_gated[`GP6_PIN_SCK];
         o_serial_data_in     <= in_gated[`GP6_PIN_SIN];
      end
   end

   //----------------------------------------------------------------------
   // Register writes
   //----------------------------------------------------------------------
   always_ff @(posedge i_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         data_r <= `GP6_RST_DATA;
      end else if (i_ce && i_req.wr && hit(i_req, `GP6_OFF_DATA)) begin
         data_r <= i_req.wdata[WIDTH-1:0];
      end
   end

   always_ff @(posedge i_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         dir_r <= `GP6_RST_DIR;
      end else if (i_ce && i_req.wr && hit(i_req, `GP6_OFF_DIR)) begin
         dir_r <= i_req.wdata[WIDTH-1:0];
      end
   end

   always_ff @(posedge i_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         pull_r <= `GP6_RST_PULL;
      end else if (i_ce && i_req.wr && hit(i_req, `GP6_OFF_PULL)) begin
         pull_r <= i_req.wdata[WIDTH-1:0];
      end
   end

   always_ff @(posedge i_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         stby_r <= `GP6_RST_STBY;
      end else if (i_ce && i_req.wr && hit(i_req, `GP6_OFF_STBY)) begin
         stby_r <= {5'h00, i_req.wdata[2:0]};
      end
   end

   //----------------------------------------------------------------------
   // Register reads
   //----------------------------------------------------------------------
   always_comb begin
      rdata_nxt = 8'h00;
      case (i_req.addr)
         `GP6_OFF_DATA: begin
            // Output pins echo the latch; others show the pin unless RMW
            rdata_nxt = i_req.rmw ? data_r
                      : ((data_r & dir_r & ~per.oe) | (in_gated & ~(dir_r & ~per.oe)));
         end
         `GP6_OFF_DIR:    rdata_nxt = dir_r;
         `GP6_OFF_PULL:   rdata_nxt = pull_r;
         `GP6_OFF_STBY:   rdata_nxt = stby_r;
         `GP6_OFF_STATUS: rdata_nxt = {7'h00, parked};
         default:         rdata_nxt = 8'h00;
      endcase
   end

   always_ff @(posedge i_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         o_rdata <= 8'h00;
      end else if (i_ce) begin
         o_rdata <= i_req.rd ? rdata_nxt : 8'h00;
      end
   end

endmodule : gp6_port

// file: verif/gp6_board.sv
// Board model: far-side drivers, pull-ups and floating pins
module gp6_board (
   // Clock and port drive
   input  wire logic       i_clk,
   input  wire logic [7:0] i_out,
   input  wire logic [7:0] i_oe,
   input  wire logic [7:0] i_pu,
   // Far-side drivers
   input  wire logic [7:0] i_ext_en,
   input  wire logic [7:0] i_ext_val,
   output logic [7:0]      o_lvl
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [7:0] float_r = 8'h55;
   // A floating pin toggles so a stale level never passes for a driven one
   always @(posedge i_clk) float_r <= ~float_r;
   always_comb o_lvl = (i_oe & i_out) | (~i_oe & i_ext_en & i_ext_val)
                     | (~i_oe & ~i_ext_en & (i_pu | float_r));
endmodule : gp6_board

// file: verif/gp6_port_sva.sv
// Assertions on the pins and read port of the port-six block
`include "gp6_cfg.svh"
module gp6_port_sva
   import gp6_pkg::*;
(
   // Clock and bus
   input wire logic       i_clk,
   input wire logic       i_nrst,
   input wire logic       i_ce,
   input wire gp6_req_t   i_req,
   input wire logic [7:0] o_rdata,
   input wire logic       i_standby,
   // Pins
   input wire logic [7:0] i_periph_oe,
   input wire logic       o_comp_timer1_clk_in,
   input wire logic [7:0] o_pin,
   input wire logic [7:0] o_pin_oe,
   input wire logic [7:0] o_pullup_en
);
   logic [7:0] data_r, dir_r, pe;
   logic [1:0] live_r;
   logic       spl_r, park;
   assign pe = i_periph_oe & 8'h6F;
   assign park = i_standby && spl_r && i_ce;
   // Shadow copies predict drive values from bus traffic alone
   always_ff @(posedge i_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         {data_r, dir_r, spl_r, live_r} <= '0;
      end else begin
         live_r <= {live_r[0], i_ce && !i_standby};
         if (i_ce && i_req.wr && i_req.addr == `GP6_OFF_DATA) data_r <= i_req.wdata;
         if (i_ce && i_req.wr && i_req.addr == `GP6_OFF_DIR) dir_r <= i_req.wdata;
         if (i_ce && i_req.wr && i_req.addr == `GP6_OFF_STBY) spl_r <= i_req.wdata[`GP6_STBY_PIN_BIT];
      end
   end
   default clocking @(posedge i_clk); endclocking
   default disable iff (!i_nrst);
   AST_OE_FOLLOWS: assert property (&live_r |-> o_pin_oe == $past(dir_r | pe))
      else $error("drive enable mismatch");
   AST_LATCH_DRIVE: assert property (&live_r
      |-> ((o_pin ^ $past(data_r)) & $past(dir_r & ~pe)) == 8'h00) else $error("output pin not at latch value");
   AST_OUT_READ: assert property ($past(i_req.rd && !i_req.rmw && i_ce && i_req.addr == `GP6_OFF_DATA)
      |-> ((o_rdata ^ $past(data_r)) & $past(dir_r & ~pe)) == 8'h00) else $error("output read not latch");
   AST_RMW_LATCH: assert property ($past(i_req.rd && i_req.rmw && i_ce && i_req.addr == `GP6_OFF_DATA)
      |-> o_rdata == $past(data_r)) else $error("rmw read not latch");
   AST_PARK_HIZ: assert property (park [*3] |-> (o_pin_oe | o_pullup_en) == 8'h00)
      else $error("parked pin still driven");
   AST_PARK_IN_LOW: assert property (park [*8] |-> !o_comp_timer1_clk_in)
      else $error("parked input not low");
   AST_PULL_OFF_LOW: assert property ((o_pullup_en & o_pin_oe & ~o_pin) == 8'h00)
      else $error("pull-up on a low pin");
   AST_RESET_IN: assert property ($rose(i_nrst) |-> o_pin_oe == 8'h00)
      else $error("pin driven after reset");
   cover property (park [*3]);
   cover property (i_req.rd && i_req.rmw);
   cover property (&live_r && pe != 8'h00);
endmodule : gp6_port_sva

bind gp6_port gp6_port_sva chk_u (.i_clk(i_clk), .i_nrst(i_nrst), .i_ce(i_ce), .i_req(i_req), .o_rdata(o_rdata),
   .i_standby(i_standby), .i_periph_oe(i_periph_oe), .o_comp_timer1_clk_in(o_comp_timer1_clk_in),
   .o_pin(o_pin), .o_pin_oe(o_pin_oe), .o_pullup_en(o_pullup_en));

// file: verif/gp6_port_tb_top.sv
// Self-checking testbench for the port-six block
`include "gp6_cfg.svh"
module gp6_port_tb_top
   import gp6_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   logic       i_clk = 1'b0, i_nrst = 1'b0, i_ce = 1'b1, standby = 1'b0, sck_en = 1'b0, sin_en = 1'b0;
   logic       tclk_in, sclk_in, sdin;
   logic [5:0] pv = 6'h00;
   logic [7:0] poe = 8'h00, ext_en = 8'h00, ext_val = 8'h00, rdata, lvl, pin, pin_oe, pull_en;
   gp6_req_t   req = '0;
   int         bad_count = 0, comparisons = 0;
   gp6_port dut_u (.i_clk(i_clk), .i_nrst(i_nrst), .i_ce(i_ce), .i_req(req), .o_rdata(rdata), .i_standby(standby),
      .i_irq_sck_en(sck_en), .i_irq_sin_en(sin_en), .i_pulse_gen1_out_a(pv[0]), .i_pulse_gen1_out_b(pv[1]),
      .i_comp_timer1_out_a(pv[2]), .i_comp_timer1_out_b(pv[3]), .i_serial_clk_out(pv[4]), .i_serial_data_out(pv[5]),
      .i_periph_oe(poe), .o_comp_timer1_clk_in(tclk_in), .o_serial_clk_in(sclk_in), .o_serial_data_in(sdin),
      .i_pin(lvl), .o_pin(pin), .o_pin_oe(pin_oe), .o_pullup_en(pull_en));
   gp6_board board_u (.i_clk(i_clk), .i_out(pin), .i_oe(pin_oe), .i_pu(pull_en), .i_ext_en(ext_en),
      .i_ext_val(ext_val), .o_lvl(lvl));
   initial forever #5 i_clk = ~i_clk;
   // The run needs about 120 cycles; this cuts a hang short
   initial begin
      #20000;
      bad_count++;
      test_done;
   end
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      comparisons++;
      if (got !== exp) begin
         bad_count++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk
   task automatic tick(input int n);
      repeat (n) @(posedge i_clk);
      #1;
   endtask : tick
   // A spare cycle after each strobe keeps one assignment per time step
   task automatic wr(input logic [3:0] a, input logic [7:0] d);
      req <= {a, d, 3'b100};
      @(posedge i_clk);
      req <= '0;
      @(posedge i_clk);
   endtask : wr
   task automatic rd(input logic [3:0] a, input logic m, input logic [7:0] exp);
      req <= {a, 8'h00, 2'b01, m};
      @(posedge i_clk);
      req <= '0;
      #1 chk(rdata, exp);
      @(posedge i_clk);
   endtask : rd
   task automatic test_done;
      $display("comparisons %0d bad_count %0d", comparisons, bad_count);
      if (bad_count == 0 && comparisons > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask : test_done
   task automatic t_reset;
      rd(`GP6_OFF_DIR, 1'b0, `GP6_RST_DIR);
      wr(4'hF, 8'hFF);
      rd(4'hF, 1'b0, 8'h00);
      #1 chk(pin_oe, 8'h00);
   endtask : t_reset
   task automatic t_output;
      {ext_en, ext_val} <= 16'hF030;
      wr(`GP6_OFF_DIR, 8'h0F);
      wr(`GP6_OFF_DATA, 8'hA5);
      tick(8);
      chk(pin_oe, 8'h0F);
      chk(pin & 8'h0F, 8'h05);
      rd(`GP6_OFF_DATA, 1'b0, 8'h35);
      rd(`GP6_OFF_DATA, 1'b1, 8'hA5);
   endtask : t_output
   task automatic t_periph;
      wr(`GP6_OFF_DIR, 8'h00);
      {ext_en, ext_val} <= 16'h9090;
      {pv, poe} <= 14'h15FF;
      tick(8);
      chk(pin_oe, 8'h6F);
      chk(pin & 8'h6F, 8'h25);
      chk(8'({tclk_in, sdin}), 8'h03);
      rd(`GP6_OFF_DATA, 1'b0, 8'hB5);
      rd(`GP6_OFF_DATA, 1'b1, 8'hA5);
      poe <= 8'h00;
   endtask : t_periph
   task automatic t_pull;
      {ext_en, ext_val} <= 16'h0000;
      wr(`GP6_OFF_DIR, 8'hFF);
      wr(`GP6_OFF_DATA, 8'h0F);
      wr(`GP6_OFF_PULL, 8'hFF);
      tick(4);
      chk(pull_en, 8'h0F);
   endtask : t_pull
   task automatic t_park;
      wr(`GP6_OFF_DIR, 8'h4F);
      {ext_en, ext_val} <= 16'hB0B0;
      wr(`GP6_OFF_STBY, 8'h01);
      standby <= 1'b1;
      tick(10);
      chk(pin_oe | pull_en, 8'h00);
      chk(8'({tclk_in, sclk_in, sdin}), 8'h00);
      rd(`GP6_OFF_STATUS, 1'b0, 8'h01);
      {sck_en, sin_en} <= 2'b11;
      wr(`GP6_OFF_STBY, 8'h07);
      tick(8);
      chk(8'({tclk_in, sclk_in, sdin}), 8'h03);
      standby <= 1'b0;
   endtask : t_park
   task automatic t_hold;
      tick(4);
      wr(`GP6_OFF_STBY, 8'h00);
      standby <= 1'b1;
      tick(6);
      chk(pin_oe, 8'h4F);
      chk(pin & 8'h4F, 8'h0F);
      standby <= 1'b0;
   endtask : t_hold
   task automatic t_ce;
      i_ce <= 1'b0;
      wr(`GP6_OFF_DATA, 8'h00);
      i_ce <= 1'b1;
      rd(`GP6_OFF_DATA, 1'b1, 8'h0F);
   endtask : t_ce
   // A reset in mid-run must drop the drive enables left by earlier scenarios
   task automatic t_rst_mid;
      i_nrst <= 1'b0;
      tick(2);
      chk(pin_oe, 8'h00);
      i_nrst <= 1'b1;
      tick(2);
      rd(`GP6_OFF_DIR, 1'b0, `GP6_RST_DIR);
   endtask : t_rst_mid
   initial begin
      // Reset stays low for the first 20 edges
      repeat (20) @(posedge i_clk);
      i_nrst <= 1'b1;
      @(posedge i_clk);
      t_reset;
      t_output;
      t_periph;
      t_pull;
      t_park;
      t_hold;
      t_ce;
      t_rst_mid;
      test_done;
   end
endmodule : gp6_port_tb_top
